//--- hdl/sysctl_mask_override_c2_c8_decode.sv
`timescale 1ns/100ps
`default_nettype none
module sysctl_mask_override_c2_c8_decode
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire sysctl_pkg::access_type  access,
   input  wire sysctl_pkg::status_type  status,
   output logic                         access_done,
   output logic                         access_undefined,
   output logic [31:0]                  read_data,
   output logic                         abort_mask_effective,
   output logic                         irq_mask_effective,
   output logic                         fiq_mask_effective,
   output sysctl_pkg::op_type           op_strobe,
   output logic                         tlb_keep_locked
);

   logic [31:0]          exception_mask_override;
   logic [31:0]          table_base_zero [2];
   logic [31:0]          table_base_one [2];
   logic [31:0]          table_base_control [2];
   logic [31:0]          domain_access_control [2];
   logic [31:0]          data_fault_status;
   logic [31:0]          instr_fault_status;
   logic [31:0]          aux_data_fault_status;
   logic [31:0]          aux_instr_fault_status;
   logic [31:0]          data_fault_address;
   logic [31:0]          instr_fault_address;
   logic [31:0]          translation_result;
   sysctl_pkg::sel_type  sel;
   logic                 legal;
   logic                 bank;
   logic                 wr;
   logic                 next_undefined;
   logic [31:0]          next_read_data;

   // decode one access; only the coprocessor number and op1 0 are implemented
   function automatic sysctl_pkg::sel_type decode(input sysctl_pkg::access_type a);
      sysctl_pkg::sel_type s;
      s = sysctl_pkg::sel_none;
      if (a.coproc == sysctl_pkg::coproc_sysctl && a.op1 == sysctl_pkg::op1_zero)
      begin
         unique case (a.crn)
            sysctl_pkg::crn_c1:
               if (a.crm == sysctl_pkg::crm_c1 && a.op2 == sysctl_pkg::op2_override)
                  s = sysctl_pkg::sel_override;
            sysctl_pkg::crn_c2:
               if (a.crm == sysctl_pkg::crm_c0)
               begin
                  if (a.op2 == sysctl_pkg::op2_zero) s = sysctl_pkg::sel_base_zero;
                  else if (a.op2 == sysctl_pkg::op2_one) s = sysctl_pkg::sel_base_one;
                  else if (a.op2 == sysctl_pkg::op2_two) s = sysctl_pkg::sel_base_control;
               end
            sysctl_pkg::crn_c3:
               if (a.crm == sysctl_pkg::crm_c0 && a.op2 == sysctl_pkg::op2_zero)
                  s = sysctl_pkg::sel_domain;
            sysctl_pkg::crn_c5:
               if (a.crm == sysctl_pkg::crm_c0)
               begin
                  if (a.op2 == sysctl_pkg::op2_zero) s = sysctl_pkg::sel_dfs;
                  else if (a.op2 == sysctl_pkg::op2_one) s = sysctl_pkg::sel_ifs;
               end
               else if (a.crm == sysctl_pkg::crm_c1)
               begin
                  if (a.op2 == sysctl_pkg::op2_zero) s = sysctl_pkg::sel_adfs;
                  else if (a.op2 == sysctl_pkg::op2_one) s = sysctl_pkg::sel_aifs;
               end
            sysctl_pkg::crn_c6:
               if (a.crm == sysctl_pkg::crm_c0)
               begin
                  if (a.op2 == sysctl_pkg::op2_zero) s = sysctl_pkg::sel_dfa;
                  else if (a.op2 == sysctl_pkg::op2_two) s = sysctl_pkg::sel_ifa;
               end
            // every c7 write is accepted; only named ones act
            sysctl_pkg::crn_c7:
               if (a.crm == 4'h0004 && a.op2 == sysctl_pkg::op2_zero)
                  s = sysctl_pkg::sel_result;
               else if (a.write)
                  s = sysctl_pkg::sel_write_op;
            sysctl_pkg::crn_c8:
               if (a.write)
                  s = sysctl_pkg::sel_write_op;
            // c4 and the rest decode to nothing
            default:
               s = sysctl_pkg::sel_none;
         endcase
      end
      return s;
   endfunction : decode

   // c7 writes that name a cache, branch predictor, barrier or address operation;
   // reserved slots must never reach the caches, so they give no strobe at all
   function automatic logic c7_named_op(input logic [3:0] crm, input logic [2:0] op2);
      logic named;
      named = 1'b0;
      unique case (crm)
         sysctl_pkg::crm_c1: named = (op2 == 3'h0 || op2 == 3'h6);
         sysctl_pkg::crm_c5: named = (op2 == 3'h0 || op2 == 3'h1 || op2 == 3'h4 || op2 == 3'h6);
         4'h0006:            named = (op2 == 3'h1 || op2 == 3'h2);
         4'h0008:            named = 1'b1;
         4'h000a:            named = (op2 == 3'h1 || op2 == 3'h2 || op2 == 3'h4 || op2 == 3'h5);
         4'h000b:            named = (op2 == 3'h1);
         4'h000e:            named = (op2 == 3'h1 || op2 == 3'h2);
         default:            named = 1'b0;
      endcase
      return named;
   endfunction : c7_named_op

   // banked copies pick by security state of the access
   assign sel  = decode(access);
   assign bank = status.non_secure;
   assign wr   = access.valid && access.write;

   // legality: user mode accesses are all undefined, override is Secure only
   always_comb
   begin
      legal = status.privileged && sel != sysctl_pkg::sel_none;
      if (sel == sysctl_pkg::sel_override && status.non_secure)
         legal = 1'b0;
      next_undefined = access.valid && !legal;
   end

   // read mux; unimplemented bits read as zero
   always_comb
   begin
      next_read_data = sysctl_pkg::word_zero;
      unique case (sel)
         sysctl_pkg::sel_override:     next_read_data = exception_mask_override;
         sysctl_pkg::sel_base_zero:    next_read_data = table_base_zero[bank];
         sysctl_pkg::sel_base_one:     next_read_data = table_base_one[bank];
         sysctl_pkg::sel_base_control: next_read_data = table_base_control[bank];
         sysctl_pkg::sel_domain:       next_read_data = domain_access_control[bank];
         sysctl_pkg::sel_dfs:          next_read_data = data_fault_status;
         sysctl_pkg::sel_ifs:          next_read_data = instr_fault_status;
         sysctl_pkg::sel_adfs:         next_read_data = aux_data_fault_status;
         sysctl_pkg::sel_aifs:         next_read_data = aux_instr_fault_status;
         sysctl_pkg::sel_dfa:          next_read_data = data_fault_address;
         sysctl_pkg::sel_ifa:          next_read_data = instr_fault_address;
         sysctl_pkg::sel_result:       next_read_data = translation_result;
         default:                      next_read_data = sysctl_pkg::word_zero;
      endcase
   end

   // access answer, one cycle after the request
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         access_done      <= 1'b0;
         access_undefined <= 1'b0;
         read_data        <= sysctl_pkg::word_zero;
      end
      else
      begin
         access_done      <= access.valid;
         access_undefined <= next_undefined;
         read_data        <= (access.valid && !access.write && legal) ? next_read_data : sysctl_pkg::word_zero;
      end
   end

   // override register keeps only its three implemented bits
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         exception_mask_override <= sysctl_pkg::override_reset;
      else if (wr && legal && sel == sysctl_pkg::sel_override)
      begin
         exception_mask_override <= sysctl_pkg::word_zero;
         exception_mask_override[sysctl_pkg::abort_override_pos] <= access.wdata[sysctl_pkg::abort_override_pos];
         exception_mask_override[sysctl_pkg::irq_override_pos]   <= access.wdata[sysctl_pkg::irq_override_pos];
         exception_mask_override[sysctl_pkg::fiq_override_pos]   <= access.wdata[sysctl_pkg::fiq_override_pos];
      end
   end

   // banked translation registers; non-secure control copy has no defined reset
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         table_base_control[0] <= sysctl_pkg::control_secure_reset;
      end
      else if (wr && legal)
      begin
         unique case (sel)
            sysctl_pkg::sel_base_zero:    table_base_zero[bank]       <= access.wdata;
            sysctl_pkg::sel_base_one:     table_base_one[bank]        <= access.wdata;
            sysctl_pkg::sel_base_control: table_base_control[bank]    <= access.wdata;
            sysctl_pkg::sel_domain:       domain_access_control[bank] <= access.wdata;
            default:                      ;
         endcase
      end
   end

   // fault and translation result registers, no reset value
   always_ff @(posedge ref_clk)
   begin
      if (wr && legal)
      begin
         unique case (sel)
            sysctl_pkg::sel_dfs:    data_fault_status      <= access.wdata;
            sysctl_pkg::sel_ifs:    instr_fault_status     <= access.wdata;
            sysctl_pkg::sel_adfs:   aux_data_fault_status  <= access.wdata;
            sysctl_pkg::sel_aifs:   aux_instr_fault_status <= access.wdata;
            sysctl_pkg::sel_dfa:    data_fault_address     <= access.wdata;
            sysctl_pkg::sel_ifa:    instr_fault_address    <= access.wdata;
            sysctl_pkg::sel_result: translation_result     <= access.wdata;
            default:                ;
         endcase
      end
   end

   // maintenance strobes, one cycle each; caches and tlb act on them elsewhere
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         op_strobe       <= '0;
         tlb_keep_locked <= 1'b0;
      end
      else
      begin
         op_strobe       <= '0;
         tlb_keep_locked <= 1'b0;
         if (wr && legal && sel == sysctl_pkg::sel_write_op)
         begin
            if (access.crn == sysctl_pkg::crn_c7)
            begin
               if (access.crm == sysctl_pkg::crm_c0)
                  op_strobe.wait_for_interrupt <= (access.op2 == sysctl_pkg::op2_four);
               // reserved slots fall through with no strobe
               else
                  op_strobe.cache_or_barrier <= c7_named_op(access.crm, access.op2);
            end
            else if (access.crm == sysctl_pkg::crm_c3 ||
                     (access.crm >= sysctl_pkg::crm_c5 && access.crm <= sysctl_pkg::crm_c7))
            begin
               op_strobe.tlb_inner_shareable <= (access.crm == sysctl_pkg::crm_c3);
               if (access.op2 == sysctl_pkg::op2_zero)
               begin
                  op_strobe.tlb_invalidate_all <= 1'b1;
                  tlb_keep_locked              <= 1'b1;
               end
               else if (access.op2 == sysctl_pkg::op2_three)
               begin
                  op_strobe.tlb_invalidate_addr_all_asid <= 1'b1;
                  tlb_keep_locked                        <= 1'b1;
               end
               else if (access.op2 <= sysctl_pkg::op2_two)
                  op_strobe.tlb_invalidate_other <= 1'b1;
            end
         end
      end
   end

   // effective masks, registered; routing only counts in non-secure state
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         abort_mask_effective <= 1'b1;
         irq_mask_effective   <= 1'b1;
         fiq_mask_effective   <= 1'b1;
      end
      else
      begin
         abort_mask_effective <= status.abort_mask && !(status.non_secure && status.external_abort_routing_bit &&
                                 exception_mask_override[sysctl_pkg::abort_override_pos]);
         irq_mask_effective   <= status.irq_mask && !(status.non_secure && status.irq_routing_bit &&
                                 exception_mask_override[sysctl_pkg::irq_override_pos]);
         fiq_mask_effective   <= status.fiq_mask && !(status.non_secure && status.fiq_routing_bit &&
                                 exception_mask_override[sysctl_pkg::fiq_override_pos]);
      end
   end

endmodule : sysctl_mask_override_c2_c8_decode
`default_nettype wire

//--- hdl/sysctl_pkg.sv
package sysctl_pkg;

   // coprocessor access encoding fields
   localparam logic [3:0] coproc_sysctl        = 4'h000f;
   localparam logic [2:0] op1_zero             = 3'h0;
   localparam logic [3:0] crn_c1               = 4'h0001;
   localparam logic [3:0] crn_c2               = 4'h0002;
   localparam logic [3:0] crn_c3               = 4'h0003;
   localparam logic [3:0] crn_c5               = 4'h0005;
   localparam logic [3:0] crn_c6               = 4'h0006;
   localparam logic [3:0] crn_c7               = 4'h0007;
   localparam logic [3:0] crn_c8               = 4'h0008;
   localparam logic [3:0] crm_c0               = 4'h0000;
   localparam logic [3:0] crm_c1               = 4'h0001;
   localparam logic [3:0] crm_c3               = 4'h0003;
   localparam logic [3:0] crm_c5               = 4'h0005;
   localparam logic [3:0] crm_c7               = 4'h0007;
   localparam logic [2:0] op2_override         = 3'h3;
   localparam logic [2:0] op2_zero             = 3'h0;
   localparam logic [2:0] op2_one              = 3'h1;
   localparam logic [2:0] op2_two              = 3'h2;
   localparam logic [2:0] op2_three            = 3'h3;
   localparam logic [2:0] op2_four             = 3'h4;

   // override register field positions
   localparam int abort_override_pos           = 8;
   localparam int irq_override_pos             = 7;
   localparam int fiq_override_pos             = 6;

   // reset values
   localparam logic [31:0] override_reset      = 32'h0000_0000;
   localparam logic [31:0] control_secure_reset = 32'h0000_0000;
   localparam logic [31:0] word_zero           = 32'h0000_0000;

   // one coprocessor access from the pipeline
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [3:0]  coproc;
      logic [2:0]  op1;
      logic [3:0]  crn;
      logic [3:0]  crm;
      logic [2:0]  op2;
      logic [31:0] wdata;
   } access_type;

   // processor status seen by the slice
   typedef struct packed {
      logic non_secure;
      logic privileged;
      logic external_abort_routing_bit;
      logic irq_routing_bit;
      logic fiq_routing_bit;
      logic abort_mask;
      logic irq_mask;
      logic fiq_mask;
   } status_type;

   // one-cycle maintenance strobes
   typedef struct packed {
      logic wait_for_interrupt;
      logic tlb_invalidate_all;
      logic tlb_invalidate_addr_all_asid;
      logic tlb_invalidate_other;
      logic tlb_inner_shareable;
      logic cache_or_barrier;
   } op_type;

   // register selected by the decoder
   typedef enum {
      sel_none, sel_override, sel_base_zero, sel_base_one, sel_base_control,
      sel_domain, sel_dfs, sel_ifs, sel_adfs, sel_aifs, sel_dfa, sel_ifa,
      sel_result, sel_write_op
   } sel_type;

endpackage : sysctl_pkg

//--- verification/core_model.sv
`timescale 1ns/100ps
`default_nettype none
// pipeline side of the slice: issues one coprocessor access at a time
module core_model
(
   input  wire logic              ref_clk,
   input  wire logic              access_done,
   input  wire logic              access_undefined,
   input  wire logic [31:0]       read_data,
   output sysctl_pkg::access_type access,
   output sysctl_pkg::status_type status
);
   // idle until the bench asks for traffic
   initial
   begin
      access = '0;
      status = '0;
   end

   // one access on a falling edge, answer taken one cycle later;
   // gap + 1 idle cycles before each access model a slow pipeline
   task automatic issue
   (
      input  logic        wr,
      input  logic [3:0]  crn,
      input  logic [3:0]  crm,
      input  logic [2:0]  op2,
      input  logic [31:0] wd,
      input  int          gap,
      output logic [33:0] rsp
   );
      repeat (gap + 1) @(negedge ref_clk);
      access = '{1'b1, wr, sysctl_pkg::coproc_sysctl, sysctl_pkg::op1_zero, crn, crm, op2, wd};
      @(negedge ref_clk);
      rsp = {access_done, access_undefined, read_data};
      access.valid = 1'b0;
      // stale write data flips so it never passes for a fresh value
      access.wdata = ~wd;
   endtask : issue

   // status levels change only on a falling edge
   task automatic set_status(input sysctl_pkg::status_type s);
      @(negedge ref_clk);
      status = s;
   endtask : set_status
endmodule : core_model
`default_nettype wire

//--- verification/sysctl_mask_override_c2_c8_decode_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sysctl_decode_checker
(
   input wire logic                   ref_clk,
   input wire logic                   rst,
   input wire sysctl_pkg::access_type access,
   input wire sysctl_pkg::status_type status,
   input wire logic                   access_done,
   input wire logic                   access_undefined,
   input wire logic [31:0]            read_data,
   input wire logic                   abort_mask_effective,
   input wire logic                   irq_mask_effective,
   input wire logic                   fiq_mask_effective,
   input wire sysctl_pkg::op_type     op_strobe,
   input wire logic                   tlb_keep_locked
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   logic       head;
   logic       ovr_hit;
   logic [2:0] ovr;
   logic [2:0] exp_mask;

   // privileged access aimed at this coprocessor
   assign head = access.valid && access.coproc == sysctl_pkg::coproc_sysctl
                 && access.op1 == sysctl_pkg::op1_zero && status.privileged;
   assign ovr_hit = head && !status.non_secure && access.crn == sysctl_pkg::crn_c1
                    && access.crm == sysctl_pkg::crm_c1 && access.op2 == sysctl_pkg::op2_override;

   // shadow of the override bits, since the register itself is not at the ports
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ovr <= 3'h0;
      else if (ovr_hit && access.write)
         ovr <= access.wdata[8:6];
   end

   // expected masks: status mask cleared only by non-secure, routing and override
   assign exp_mask = {status.abort_mask, status.irq_mask, status.fiq_mask}
                     & ~({3{status.non_secure}} & ovr & {status.external_abort_routing_bit,
                         status.irq_routing_bit, status.fiq_routing_bit});

   a_answer_next:
      assert property (access.valid |=> access_done) else $error("access not answered");
   a_idle_quiet:
      assert property (!access.valid |=> !access_done && op_strobe == '0 && !tlb_keep_locked)
      else $error("output without access");
   a_user_refused:
      assert property (access.valid && !status.privileged |=> access_undefined && read_data == 32'h0000_0000)
      else $error("user access not refused");
   a_ns_override_refused:
      assert property (access.valid && status.non_secure && access.crn == sysctl_pkg::crn_c1
                       && access.crm == sysctl_pkg::crm_c1 && access.op2 == sysctl_pkg::op2_override
                       |=> access_undefined) else $error("non-secure override access accepted");
   a_c4_refused:
      assert property (access.valid && access.crn == 4'h4 |=> access_undefined) else $error("c4 accepted");
   a_wfi_pulse:
      assert property (head && access.write && access.crn == sysctl_pkg::crn_c7 && access.crm == sysctl_pkg::crm_c0
                       && access.op2 == sysctl_pkg::op2_four |=> op_strobe.wait_for_interrupt && !access_undefined)
      else $error("wait strobe missing");
   a_keep_locked:
      assert property (head && access.write && access.crn == sysctl_pkg::crn_c8 && access.crm == sysctl_pkg::crm_c3
                       && (access.op2 == sysctl_pkg::op2_zero || access.op2 == sysctl_pkg::op2_three)
                       |=> tlb_keep_locked) else $error("locked entries not kept");
   a_abort_mask:
      assert property (!$past(rst) |-> abort_mask_effective == $past(exp_mask[2])) else $error("abort mask wrong");
   a_irq_mask:
      assert property (!$past(rst) |-> irq_mask_effective == $past(exp_mask[1])) else $error("irq mask wrong");
   a_fiq_mask:
      assert property (!$past(rst) |-> fiq_mask_effective == $past(exp_mask[0])) else $error("fiq mask wrong");

   // main scenarios reached
   c_ovr_write: cover property (ovr_hit && access.write);
   c_tlb_op: cover property (head && access.crn == sysctl_pkg::crn_c8);
   c_irq_open: cover property (status.non_secure && status.irq_mask && !irq_mask_effective);
   c_cache_op: cover property (op_strobe.cache_or_barrier);
endmodule : sysctl_decode_checker

bind sysctl_mask_override_c2_c8_decode sysctl_decode_checker chk_i (.ref_clk(ref_clk), .rst(rst), .access(access),
   .status(status), .access_done(access_done), .access_undefined(access_undefined), .read_data(read_data),
   .abort_mask_effective(abort_mask_effective), .irq_mask_effective(irq_mask_effective),
   .fiq_mask_effective(fiq_mask_effective), .op_strobe(op_strobe), .tlb_keep_locked(tlb_keep_locked));
`default_nettype wire

//--- verification/test_sysctl_mask_override_c2_c8_decode.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("BAD %s expected %h seen %h", what, exp, got); \
      end \
   end
module test_sysctl_mask_override_c2_c8_decode;
   logic                   ref_clk;
   logic                   rst;
   sysctl_pkg::access_type access;
   sysctl_pkg::status_type status;
   logic                   access_done;
   logic                   access_undefined;
   logic [31:0]            read_data;
   logic                   abort_mask_effective;
   logic                   irq_mask_effective;
   logic                   fiq_mask_effective;
   sysctl_pkg::op_type     op_strobe;
   logic                   tlb_keep_locked;
   logic [33:0]            rsp;
   logic [10:0]            enc [11];
   int                     gap;
   int                     n_mismatch;
   int                     cmp_count;
   int                     cycles;
   localparam logic [10:0] ovr_enc = 11'h08B;

   sysctl_mask_override_c2_c8_decode dut (.ref_clk(ref_clk), .rst(rst), .access(access), .status(status),
      .access_done(access_done), .access_undefined(access_undefined), .read_data(read_data),
      .abort_mask_effective(abort_mask_effective), .irq_mask_effective(irq_mask_effective),
      .fiq_mask_effective(fiq_mask_effective), .op_strobe(op_strobe), .tlb_keep_locked(tlb_keep_locked));
   core_model core (.ref_clk(ref_clk), .access_done(access_done), .access_undefined(access_undefined),
      .read_data(read_data), .access(access), .status(status));

   // 50 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   // one access, encoding packed as {crn, crm, op2}
   task automatic acc(input logic w, input logic [10:0] e, input logic [31:0] d);
      core.issue(w, e[10:7], e[6:3], e[2:0], d, gap, rsp);
   endtask : acc

   // new status, then the registered masks one cycle on
   task automatic mask(input logic [7:0] s, input logic [2:0] e);
      core.set_status(s);
      @(negedge ref_clk);
      `CHK("masks", e, {abort_mask_effective, irq_mask_effective, fiq_mask_effective})
   endtask : mask

   // main sequence
   initial
   begin
      rst = 1'b1;
      gap = 0;
      cycles = 0;
      n_mismatch = 0;
      cmp_count = 0;
      enc = '{11'h100, 11'h101, 11'h102, 11'h180, 11'h280, 11'h281, 11'h288, 11'h289, 11'h300, 11'h302, 11'h3A0};
      core.set_status(8'h47);
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      `CHK("reset masks", 3'h7, {abort_mask_effective, irq_mask_effective, fiq_mask_effective})
      acc(1'b0, ovr_enc, 32'h0000_0000);
      `CHK("override reset", {2'h2, 32'h0000_0000}, rsp)
      acc(1'b0, 11'h102, 32'h0000_0000);
      `CHK("control reset", {2'h2, 32'h0000_0000}, rsp)
      $display("test reset done");
      acc(1'b1, ovr_enc, 32'hFFFF_FFFF);
      acc(1'b0, ovr_enc, 32'h0000_0000);
      `CHK("override bits", {2'h2, 32'h0000_01C0}, rsp)
      mask(8'hFF, 3'h0);
      for (int k = 0; k < 3; k++)
         mask({2'h3, 3'h4 >> k, 3'h7}, ~(3'h4 >> k));
      mask(8'h7F, 3'h7);
      mask(8'hF8, 3'h0);
      mask(8'hC7, 3'h7);
      acc(1'b1, ovr_enc, 32'h0000_0000);
      `CHK("ns override", {2'h3, 32'h0000_0000}, rsp)
      mask(8'h07, 3'h7);
      acc(1'b0, 11'h100, 32'h0000_0000);
      `CHK("user access", {2'h3, 32'h0000_0000}, rsp)
      mask(8'h47, 3'h7);
      acc(1'b0, ovr_enc, 32'h0000_0000);
      `CHK("override kept", {2'h2, 32'h0000_01C0}, rsp)
      $display("test override done");
      // slow pipeline for the register map
      gap = 1;
      for (int i = 0; i < 11; i++)
         acc(1'b1, enc[i], {28'hA5C_3000, i[3:0]});
      for (int i = 0; i < 11; i++)
      begin
         acc(1'b0, enc[i], 32'h0000_0000);
         `CHK("map status", 2'h2, rsp[33:32])
         if (i != 6 && i != 7)
            `CHK("map data", {28'hA5C_3000, i[3:0]}, rsp[31:0])
      end
      mask(8'hC0, 3'h0);
      acc(1'b1, 11'h102, 32'h0000_0002);
      acc(1'b0, 11'h102, 32'h0000_0000);
      `CHK("ns control", {2'h2, 32'h0000_0002}, rsp)
      mask(8'h40, 3'h0);
      acc(1'b0, 11'h102, 32'h0000_0000);
      `CHK("secure control", {2'h2, 32'hA5C3_0002}, rsp)
      $display("test map done");
      acc(1'b1, 11'h200, 32'h0000_0001);
      `CHK("c4 write", {2'h3, 32'h0000_0000}, rsp)
      acc(1'b0, 11'h200, 32'h0000_0000);
      `CHK("c4 read", {2'h3, 32'h0000_0000}, rsp)
      acc(1'b0, 11'h384, 32'h0000_0000);
      `CHK("nop read", {2'h3, 32'h0000_0000}, rsp)
      gap = 0;
      for (int o = 0; o < 5; o++)
      begin
         acc(1'b1, 11'h380 + o[10:0], 32'h0000_0000);
         `CHK("c7 answer", {2'h2, 32'h0000_0000}, rsp)
         `CHK("c7 strobe", (o == 4) ? 6'h20 : 6'h00, op_strobe)
      end
      acc(1'b1, 11'h418, 32'h0000_0000);
      `CHK("inval all", 7'h25, {op_strobe, tlb_keep_locked})
      acc(1'b1, 11'h42B, 32'h0000_0000);
      `CHK("inval addr", 7'h11, {op_strobe, tlb_keep_locked})
      acc(1'b1, 11'h439, 32'h0000_0000);
      `CHK("inval other", 7'h08, {op_strobe, tlb_keep_locked})
      acc(1'b1, 11'h38F, 32'h0000_0000);
      `CHK("c7 reserved", {2'h2, 6'h00}, {rsp[33:32], op_strobe})
      acc(1'b1, 11'h3AA, 32'h0000_0000);
      `CHK("c7 reserved", {2'h2, 6'h00}, {rsp[33:32], op_strobe})
      acc(1'b1, 11'h3A8, 32'h0000_0000);
      `CHK("cache op", {2'h2, 6'h01}, {rsp[33:32], op_strobe})
      $display("test operations done");
      stop_test();
   end
endmodule : test_sysctl_mask_override_c2_c8_decode
`default_nettype wire
